// *** rtl/efp_fan_ctrl.sv ***
/*
  External fan / PWM controller top: load type selection, thermal
  feedback with hysteresis, manual settings, linear duty ramp, full-duty
  measurement bursts for three-wire fans, and tachometer measurement.
  Assumes all settings come from logic on clk_in; only the tachometer
  pin is asynchronous.
*/
`timescale 1ns/1ps

// Operation
// - Load type is three-wire, four-wire or generic; three-wire after reset.
// - Enhanced measurement on three-wire fan forces 100% for 100 ms, then restores.
// - With enhanced measurement off, no bursts; tach measured continuously.
// - Thermal control only for fan loads; disabled for generic load.
// - Under thermal control, full duty above full-speed threshold (70..100).
// - Under thermal control, zero duty below fan-off threshold (5..100).
// - Hysteresis 0..10 added on rising, subtracted on falling temperature.
// - Between thresholds, thermal control outputs the mid-band duty 0..100.
// - Fan load, manual mode: programmable frequency 1..60000 Hz.
// - Fan load, manual mode: configured default duty 0..100.
// - Generic load: separate frequency setting 1..60000 Hz.
// - Generic load: configured default duty 0..100.
// - Duty ramps linearly to target over 0..50 s; zero applies at once.
module efp_fan_ctrl
  import efp_pkg::*;
#(
  parameter int CYCLES_PER_MS = efp_pkg::EFP_CYCLES_PER_MS // Shorten for simulation
) (
  input wire logic clk_in, // System clock, 200 MHz
  input wire logic reset_in, // Async reset, active high
  input wire logic [1:0] load_type_in, // 0 three-wire, 1 four-wire, 2 generic
  input wire logic enh_meas_en_in, // Enhanced three-wire measurement
  input wire logic auto_ctrl_en_in, // Thermal feedback control enable
  input wire logic [efp_pkg::EFP_TEMP_W-1:0] temp_in, // Temperature, deg C
  input wire logic [efp_pkg::EFP_THR_W-1:0] full_speed_threshold_in, // Deg C
  input wire logic [efp_pkg::EFP_THR_W-1:0] fan_off_threshold_in, // Deg C
  input wire logic [efp_pkg::EFP_HYST_W-1:0] hysteresis_in, // Deg C
  input wire logic [efp_pkg::EFP_DUTY_W-1:0] mid_duty_in, // Mid-band duty, %
  input wire logic [efp_pkg::EFP_FREQ_W-1:0] fan_freq_in, // Fan frequency, Hz
  input wire logic [efp_pkg::EFP_DUTY_W-1:0] fan_duty_in, // Fan manual duty, %
  input wire logic [efp_pkg::EFP_FREQ_W-1:0] gen_freq_in, // Generic frequency, Hz
  input wire logic [efp_pkg::EFP_DUTY_W-1:0] gen_duty_in, // Generic duty, %
  input wire logic [efp_pkg::EFP_SECS_W-1:0] ramp_secs_in, // Ramp duration, s
  input wire logic tachometer_input_in, // Tachometer pin, asynchronous
  output logic pwm_output_pin_out, // PWM output pin
  output logic [efp_pkg::EFP_DUTY_W-1:0] duty_out, // Duty being applied, %
  output logic burst_active_out, // Full-duty burst in progress
  output logic auto_active_out, // Thermal control in effect
  output logic [efp_pkg::EFP_CNT_W-1:0] tach_count_out, // Edges per window
  output logic tach_valid_out // Pulse on new count
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [EFP_DUTY_W-1:0] clamp_duty(input logic [EFP_DUTY_W-1:0] d);
    clamp_duty = (d > EFP_DUTY_FULL) ? EFP_DUTY_FULL : d;
  endfunction : clamp_duty

  function automatic logic [EFP_FREQ_W-1:0] clamp_freq(input logic [EFP_FREQ_W-1:0] f);
    if (f < EFP_FREQ_MIN) clamp_freq = EFP_FREQ_MIN;
    else if (f > EFP_FREQ_MAX) clamp_freq = EFP_FREQ_MAX;
    else clamp_freq = f;
  endfunction : clamp_freq

  // Threshold shifted by hysteresis, saturating at zero on the way down
  function automatic logic [EFP_TEMP_W:0] shift_thr(input logic [EFP_THR_W-1:0] t,
                                                    input logic [EFP_HYST_W-1:0] h,
                                                    input logic up);
    logic [EFP_TEMP_W:0] tw;
    logic [EFP_TEMP_W:0] hw;
    tw = (EFP_TEMP_W+1)'(t);
    hw = (EFP_TEMP_W+1)'((h > EFP_HYST_MAX) ? EFP_HYST_MAX : h);
    if (up) shift_thr = tw + hw;
    else shift_thr = (tw > hw) ? tw - hw : '0;
  endfunction : shift_thr

  // ----------------------------------------------------------------
  // Load type and mode
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {TH_OFF, TH_MID, TH_FULL} efp_therm_e;

  efp_load_e load, next_load;
  logic next_auto;
  logic is_generic;

  always_comb begin
    unique case (load_type_in)
      2'h1: next_load = EFP_LOAD_4WIRE;
      2'h2: next_load = EFP_LOAD_GENERIC;
      default: next_load = EFP_LOAD_3WIRE;
    endcase
    next_auto = auto_ctrl_en_in && (next_load != EFP_LOAD_GENERIC);
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      load <= EFP_LOAD_3WIRE;
      auto_active_out <= 1'b0;
    end else begin
      load <= next_load;
      auto_active_out <= next_auto;
    end
  end

  assign is_generic = (load == EFP_LOAD_GENERIC);

  // ----------------------------------------------------------------
  // Millisecond divider and measurement period
  // ----------------------------------------------------------------
  localparam logic [EFP_MS_W-1:0] MS_LAST = EFP_MS_W'(CYCLES_PER_MS - 1);
  localparam logic [EFP_MEAS_W-1:0] MEAS_LAST = EFP_MEAS_W'(EFP_MEAS_PERIOD_MS - 1);
  localparam logic [EFP_MEAS_W-1:0] BURST_FIRST =
    EFP_MEAS_W'(EFP_MEAS_PERIOD_MS - EFP_BURST_MS);

  logic [EFP_MS_W-1:0] ms_cnt, next_ms_cnt;
  logic [EFP_MEAS_W-1:0] meas_ms, next_meas_ms;
  logic ms_tick, next_ms_tick;
  logic window_end, next_window_end;
  logic burst_mode, next_burst, tach_gate;

  assign burst_mode = enh_meas_en_in && (load == EFP_LOAD_3WIRE);

  always_comb begin
    next_ms_tick = (ms_cnt == MS_LAST);
    next_ms_cnt = next_ms_tick ? '0 : ms_cnt + 18'h00001;
    next_meas_ms = meas_ms;
    next_window_end = 1'b0;
    if (ms_tick) begin
      next_window_end = (meas_ms == MEAS_LAST);
      next_meas_ms = (meas_ms == MEAS_LAST) ? '0 : meas_ms + 10'h001;
    end
    // Burst covers the last 100 ms of each period, ending with the window
    next_burst = burst_mode && (next_meas_ms >= BURST_FIRST) && !next_window_end;
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      ms_cnt <= '0;
      ms_tick <= 1'b0;
      meas_ms <= '0;
      window_end <= 1'b0;
      burst_active_out <= 1'b0;
    end else begin
      ms_cnt <= next_ms_cnt;
      ms_tick <= next_ms_tick;
      meas_ms <= next_meas_ms;
      window_end <= next_window_end;
      burst_active_out <= next_burst;
    end
  end

  // Bursting measures only while the fan is at full speed
  assign tach_gate = burst_mode ? burst_active_out : 1'b1;

  // ----------------------------------------------------------------
  // Thermal feedback
  // ----------------------------------------------------------------
  efp_therm_e therm, next_therm;
  logic [EFP_TEMP_W:0] temp_w, off_up, off_dn, full_up, full_dn;

  assign temp_w = (EFP_TEMP_W+1)'(temp_in);
  assign off_up = shift_thr(fan_off_threshold_in, hysteresis_in, 1'b1);
  assign off_dn = shift_thr(fan_off_threshold_in, hysteresis_in, 1'b0);
  assign full_up = shift_thr(full_speed_threshold_in, hysteresis_in, 1'b1);
  assign full_dn = shift_thr(full_speed_threshold_in, hysteresis_in, 1'b0);

  always_comb begin
    next_therm = therm;
    unique case (therm)
      TH_OFF: begin
        if (temp_w > full_up) next_therm = TH_FULL;
        else if (temp_w > off_up) next_therm = TH_MID;
      end
      TH_MID: begin
        if (temp_w > full_up) next_therm = TH_FULL;
        else if (temp_w < off_dn) next_therm = TH_OFF;
      end
      TH_FULL: begin
        if (temp_w < off_dn) next_therm = TH_OFF;
        else if (temp_w < full_dn) next_therm = TH_MID;
      end
      default: next_therm = TH_OFF;
    endcase
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) therm <= TH_OFF;
    else therm <= next_therm;
  end

  // ----------------------------------------------------------------
  // Target duty and frequency
  // ----------------------------------------------------------------
  logic [EFP_DUTY_W-1:0] target;
  logic [EFP_FREQ_W-1:0] freq;

  always_comb begin
    if (is_generic) begin
      target = clamp_duty(gen_duty_in);
      freq = clamp_freq(gen_freq_in);
    end else begin
      freq = clamp_freq(fan_freq_in);
      if (!auto_active_out) target = clamp_duty(fan_duty_in);
      else if (therm == TH_FULL) target = EFP_DUTY_FULL;
      else if (therm == TH_MID) target = clamp_duty(mid_duty_in);
      else target = EFP_DUTY_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // Linear ramp
  // ----------------------------------------------------------------
  localparam logic [EFP_RAMP_W-1:0] RAMP_MUL = EFP_RAMP_W'(EFP_RAMP_MS_PER_S);

  logic [EFP_DUTY_W-1:0] cur_duty, next_cur_duty, next_duty_out;
  logic [EFP_RAMP_W-1:0] ramp_ms, next_ramp_ms, ramp_len;
  logic [EFP_SECS_W-1:0] secs;

  assign secs = (ramp_secs_in > EFP_RAMP_MAX_S) ? EFP_RAMP_MAX_S : ramp_secs_in;
  assign ramp_len = EFP_RAMP_W'(secs * RAMP_MUL);

  always_comb begin
    next_cur_duty = cur_duty;
    next_ramp_ms = ramp_ms;
    if (secs == '0) begin
      next_cur_duty = target;
      next_ramp_ms = '0;
    end else if (cur_duty == target) begin
      next_ramp_ms = '0;
    end else if (ms_tick) begin
      if (ramp_ms + 9'h001 >= ramp_len) begin
        next_ramp_ms = '0;
        // One percent per step gives a straight line over the set seconds
        next_cur_duty = (target > cur_duty) ? cur_duty + 7'h01 : cur_duty - 7'h01;
      end else begin
        next_ramp_ms = ramp_ms + 9'h001;
      end
    end
    // Burst leaves the ramp state alone so the old duty comes back after it
    next_duty_out = next_burst ? EFP_DUTY_FULL : next_cur_duty;
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      cur_duty <= EFP_DUTY_ZERO;
      ramp_ms <= '0;
      duty_out <= EFP_DUTY_ZERO;
    end else begin
      cur_duty <= next_cur_duty;
      ramp_ms <= next_ramp_ms;
      duty_out <= next_duty_out;
    end
  end

  // ----------------------------------------------------------------
  // Output stage and tachometer
  // ----------------------------------------------------------------
  efp_pwm_core u_pwm (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .freq_in(freq),
    .duty_in(duty_out),
    .pwm_out(pwm_output_pin_out)
  );

  efp_tach u_tach (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .tach_pin_in(tachometer_input_in),
    .gate_in(tach_gate),
    .window_end_in(window_end),
    .count_out(tach_count_out),
    .valid_out(tach_valid_out)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_burst_held;
    burst_active_out ##1 burst_active_out;
  endsequence

  a_load_illegal : assert property (@(posedge clk_in) disable iff (reset_in)
    (load_type_in == 2'h3) |=> (load == EFP_LOAD_3WIRE))
    else $error("Illegal load code not mapped to three-wire");

  a_burst_full_duty : assert property (@(posedge clk_in) disable iff (reset_in)
    s_burst_held |-> (duty_out == EFP_DUTY_FULL))
    else $error("Duty not full during burst");

  a_no_burst_off : assert property (@(posedge clk_in) disable iff (reset_in)
    !burst_mode ##1 !burst_mode |-> !burst_active_out)
    else $error("Burst without enhanced three-wire mode");

  a_generic_manual : assert property (@(posedge clk_in) disable iff (reset_in)
    is_generic |-> !auto_active_out)
    else $error("Thermal control active on generic load");

  a_full_speed : assert property (@(posedge clk_in) disable iff (reset_in)
    (temp_w > full_up) ##1 $stable(temp_in) |-> (therm == TH_FULL))
    else $error("Not at full speed above threshold");

  a_fan_off : assert property (@(posedge clk_in) disable iff (reset_in)
    (auto_active_out && !is_generic && therm == TH_OFF) |-> (target == EFP_DUTY_ZERO))
    else $error("Fan not off below threshold");

  a_hyst_hold : assert property (@(posedge clk_in) disable iff (reset_in)
    (therm == TH_MID && temp_w >= off_dn && temp_w <= full_up) |=> (therm == TH_MID))
    else $error("Mid band left inside hysteresis");

  a_ramp_instant : assert property (@(posedge clk_in) disable iff (reset_in)
    (secs == '0 && !next_burst) |=> (duty_out == $past(target)))
    else $error("Zero ramp did not apply at once");

endmodule : efp_fan_ctrl

// *** rtl/efp_pkg.sv ***
/*
  Shared constants for the external fan / PWM controller: load types,
  field widths, duty and temperature limits, and timing figures.
  Assumes a single 200 MHz system clock.
*/
package efp_pkg;

  // ----------------------------------------------------------------
  // Load types
  // ----------------------------------------------------------------
  // Code zero is the three-wire fan so a cleared setting selects it
  typedef enum logic [1:0] {EFP_LOAD_3WIRE, EFP_LOAD_4WIRE, EFP_LOAD_GENERIC} efp_load_e;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int EFP_DUTY_W = 7;
  localparam int EFP_FREQ_W = 16;
  localparam int EFP_TEMP_W = 8;
  localparam int EFP_THR_W = 7;
  localparam int EFP_HYST_W = 4;
  localparam int EFP_SECS_W = 6;
  localparam int EFP_CNT_W = 16;
  localparam int EFP_ACC_W = 28;
  localparam int EFP_STEP_W = 23;
  localparam int EFP_MS_W = 18;
  localparam int EFP_RAMP_W = 9;
  localparam int EFP_MEAS_W = 10;

  // ----------------------------------------------------------------
  // Limits and values
  // ----------------------------------------------------------------
  localparam logic [EFP_DUTY_W-1:0] EFP_DUTY_ZERO = 7'h00;
  localparam logic [EFP_DUTY_W-1:0] EFP_DUTY_FULL = 7'h64;
  localparam logic [EFP_DUTY_W-1:0] EFP_PHASE_LAST = 7'h63;
  localparam logic [EFP_FREQ_W-1:0] EFP_FREQ_MIN = 16'h0001;
  localparam logic [EFP_FREQ_W-1:0] EFP_FREQ_MAX = 16'hea60;
  localparam logic [EFP_HYST_W-1:0] EFP_HYST_MAX = 4'ha;
  localparam logic [EFP_SECS_W-1:0] EFP_RAMP_MAX_S = 6'h32;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int EFP_CLK_HZ = 200_000_000;
  localparam int EFP_MS_PER_S = 1000;
  localparam int EFP_CYCLES_PER_MS = EFP_CLK_HZ / EFP_MS_PER_S;
  localparam int EFP_BURST_MS = 100;
  localparam int EFP_MEAS_PERIOD_MS = 1000;
  // A full 0..100 % ramp spans the set seconds, one percent per step
  localparam int EFP_RAMP_MS_PER_S = EFP_MS_PER_S / int'(EFP_DUTY_FULL);

endpackage : efp_pkg

// *** rtl/efp_pwm_core.sv ***
/*
  PWM waveform generator: 100 phase steps per period, paced by a phase
  accumulator. Assumes frequency and duty are already clamped in range.
*/
`timescale 1ns/1ps
module efp_pwm_core
  import efp_pkg::*;
(
  input wire logic clk_in, // System clock
  input wire logic reset_in, // Async reset, active high
  input wire logic [efp_pkg::EFP_FREQ_W-1:0] freq_in, // Output frequency in Hz
  input wire logic [efp_pkg::EFP_DUTY_W-1:0] duty_in, // Duty in percent
  output logic pwm_out // PWM waveform
);

  localparam logic [EFP_ACC_W-1:0] CLK_HZ_C = EFP_ACC_W'(EFP_CLK_HZ);

  logic [EFP_ACC_W-1:0] acc, next_acc;
  logic [EFP_DUTY_W-1:0] phase, next_phase;
  logic [EFP_DUTY_W-1:0] duty_hold, next_duty_hold;
  logic next_pwm;
  logic [EFP_STEP_W-1:0] step;
  logic [EFP_ACC_W-1:0] sum;

  // Step rate is 100 x frequency, so no divider is needed; widen first, as
  // the product does not fit the frequency width
  assign step = EFP_STEP_W'(freq_in) * EFP_STEP_W'(EFP_DUTY_FULL);
  assign sum = acc + EFP_ACC_W'(step);

  always_comb begin
    next_acc = sum;
    next_phase = phase;
    next_duty_hold = duty_hold;
    if (sum >= CLK_HZ_C) begin
      next_acc = sum - CLK_HZ_C;
      if (phase == EFP_PHASE_LAST) begin
        next_phase = EFP_DUTY_ZERO;
        next_duty_hold = duty_in;
      end else begin
        next_phase = phase + 7'h01;
      end
    end
    // Phase never reaches 100, so 0 % stays low and 100 % stays high
    next_pwm = (next_duty_hold > next_phase);
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      acc <= '0;
      phase <= '0;
      duty_hold <= '0;
      pwm_out <= 1'b0;
    end else begin
      acc <= next_acc;
      phase <= next_phase;
      duty_hold <= next_duty_hold;
      pwm_out <= next_pwm;
    end
  end

  a_pwm_level_hold : assert property (@(posedge clk_in) disable iff (reset_in)
    (duty_hold == EFP_DUTY_ZERO) ##1 (duty_hold == EFP_DUTY_ZERO) |-> !pwm_out)
    else $error("PWM not low at zero duty");

endmodule : efp_pwm_core

// *** rtl/efp_tach.sv ***
/*
  Tachometer edge counter: synchronises the pin, counts rising edges while
  the gate is open and publishes the count at each window end.
  Assumes the tachometer line idles high behind its pull-up.
*/
`timescale 1ns/1ps
module efp_tach
  import efp_pkg::*;
(
  input wire logic clk_in, // System clock
  input wire logic reset_in, // Async reset, active high
  input wire logic tach_pin_in, // Raw tachometer pin
  input wire logic gate_in, // Count edges while high
  input wire logic window_end_in, // One-cycle pulse closing a window
  output logic [efp_pkg::EFP_CNT_W-1:0] count_out, // Edges in last window
  output logic valid_out // Pulse when count_out updates
);

  logic sync1, sync2, prev;
  logic [EFP_CNT_W-1:0] cnt, next_cnt, next_count;
  logic rise;
  logic gate_q;

  assign rise = sync2 && !prev;

  always_comb begin
    // A gate that opens mid-window drops the edges seen before it, so a
    // burst window reports only edges taken at full speed
    next_cnt = (gate_in && !gate_q) ? '0 : cnt;
    next_count = count_out;
    if (rise && gate_in && (next_cnt != '1)) begin
      next_cnt = next_cnt + 16'h0001;
    end
    if (window_end_in) begin
      next_count = next_cnt;
      next_cnt = '0;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      // Idle level of the pin, so leaving reset gives no false edge
      sync1 <= 1'b1;
      sync2 <= 1'b1;
      prev <= 1'b1;
      gate_q <= 1'b1;
      cnt <= '0;
      count_out <= '0;
      valid_out <= 1'b0;
    end else begin
      sync1 <= tach_pin_in;
      sync2 <= sync1;
      prev <= sync2;
      gate_q <= gate_in;
      cnt <= next_cnt;
      count_out <= next_count;
      valid_out <= window_end_in;
    end
  end

endmodule : efp_tach

// *** tb/efp_fan_ctrl_bench.sv ***
/*
  Self-checking bench for the fan / PWM controller: manual, generic and
  thermal modes, ramp, bursts and tach counts. Assumes CYCLES_PER_MS=20.
*/
`timescale 1ns/1ps
module efp_fan_ctrl_bench;
  import efp_pkg::*;
  localparam int CPM = 20;
  logic clk_in = 1'b0, reset_in = 1'b1, enh, auto, tach, pwm, burst, auto_act, tvalid;
  logic [1:0] load;
  logic [7:0] temp;
  logic [6:0] full_thr, off_thr, mid, fduty, gduty, duty;
  logic [3:0] hyst;
  logic [15:0] ffreq, gfreq, tcount;
  logic [5:0] ramp;
  int n_mismatch = 0, n_checks = 0, hi, rises, len;
  logic seen_burst;
  logic [7:0] temps [9] = '{8'h14, 8'h22, 8'h24, 8'h4a, 8'h4c, 8'h42, 8'h40, 8'h1a, 8'h18};
  logic [6:0] duties [9] = '{7'h00, 7'h00, 7'h28, 7'h28, 7'h64, 7'h64, 7'h28, 7'h28, 7'h00};

  always #2.5 clk_in = ~clk_in;

  efp_fan_ctrl #(.CYCLES_PER_MS(CPM)) dut_u (.clk_in(clk_in), .reset_in(reset_in),
    .load_type_in(load), .enh_meas_en_in(enh), .auto_ctrl_en_in(auto), .temp_in(temp),
    .full_speed_threshold_in(full_thr), .fan_off_threshold_in(off_thr),
    .hysteresis_in(hyst), .mid_duty_in(mid), .fan_freq_in(ffreq), .fan_duty_in(fduty),
    .gen_freq_in(gfreq), .gen_duty_in(gduty), .ramp_secs_in(ramp),
    .tachometer_input_in(tach), .pwm_output_pin_out(pwm), .duty_out(duty),
    .burst_active_out(burst), .auto_active_out(auto_act), .tach_count_out(tcount),
    .tach_valid_out(tvalid));

  efp_fan_model #(.HALF_CYCLES(20)) fan_u (.clk_in(clk_in), .reset_in(reset_in),
    .pwm_in(pwm), .tach_out(tach));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask : cyc

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Counts high cycles and rising edges of the pin over n clocks
  task automatic measure(input int n, output int h, output int r);
    logic prev;
    h = 0;
    r = 0;
    prev = pwm;
    repeat (n) begin
      @(posedge clk_in);
      if (pwm === 1'b1) h++;
      if (pwm === 1'b1 && prev === 1'b0) r++;
      prev = pwm;
    end
  endtask : measure

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict

  // A full run is about 80k clocks; the limit leaves margin
  initial begin
    #(5 * 100000);
    n_mismatch++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    load <= 2'h1; enh <= 1'b0; auto <= 1'b0; temp <= 8'h14; full_thr <= 7'h46;
    off_thr <= 7'h1e; hyst <= 4'h5; mid <= 7'h28; ffreq <= 16'hea60; fduty <= 7'h00;
    gfreq <= 16'h0064; gduty <= 7'h1e; ramp <= 6'h00;
    cyc(5);
    chk({duty, pwm, burst, auto_act, tvalid}, 32'h0);
    reset_in <= 1'b0;
    cyc(3500);
    measure(3334, hi, rises);
    chk(hi, 0);
    fduty <= 7'h64;
    cyc(3500);
    measure(3334, hi, rises);
    chk(hi, 3334);
    fduty <= 7'h32;
    cyc(4);
    chk(duty, 7'h32);
    cyc(3500);
    measure(10000, hi, rises);
    chk(rises, 3);
    chk(hi >= 4900 && hi <= 5100, 1);
    // Generic load ignores thermal control and the fan settings
    load <= 2'h2; auto <= 1'b1; gfreq <= 16'hea60; ffreq <= 16'h0064;
    cyc(4);
    chk(auto_act, 0);
    chk(duty, 7'h1e);
    cyc(3500);
    measure(10000, hi, rises);
    chk(rises, 3);
    chk(hi >= 2900 && hi <= 3100, 1);
    load <= 2'h1;
    cyc(4);
    chk(auto_act, 1);
    for (int i = 0; i < 9; i++) begin
      temp <= temps[i];
      cyc(4);
      chk(duty, duties[i]);
    end
    auto <= 1'b0; fduty <= 7'h00; ffreq <= 16'hea60;
    cyc(4);
    ramp <= 6'h01; fduty <= 7'h05;
    cyc(500);
    chk(duty >= 7'h01 && duty <= 7'h04, 1);
    cyc(800);
    chk(duty, 7'h05);
    // Code 3 must act as a three-wire fan, bursts included
    ramp <= 6'h00; load <= 2'h3; enh <= 1'b1; fduty <= 7'h14;
    len = 0;
    while (burst !== 1'b1 && len < 21000) begin
      cyc(1);
      len++;
    end
    cyc(2);
    chk(duty, 7'h64);
    len = 2;
    while (burst === 1'b1 && len < 3000) begin
      cyc(1);
      len++;
    end
    chk(len, 100 * CPM);
    len = 0;
    while (tvalid !== 1'b1 && len < 5) begin
      cyc(1);
      len++;
    end
    chk(tvalid, 1);
    chk(tcount >= 16'd49 && tcount <= 16'd51, 1);
    enh <= 1'b0; load <= 2'h0;
    cyc(4);
    chk(duty, 7'h14);
    seen_burst = 1'b0;
    len = 0;
    while (tvalid !== 1'b1 && len < 21000) begin
      cyc(1);
      if (burst !== 1'b0) seen_burst = 1'b1;
      len++;
    end
    chk(seen_burst, 0);
    chk(tcount >= 16'd499 && tcount <= 16'd501, 1);
    give_verdict();
  end
endmodule : efp_fan_ctrl_bench

// *** tb/efp_fan_model.sv ***
/*
  Behavioural external fan: a spinning rotor gives a tachometer pulse
  train of fixed rate. Assumes the bench's clock; the rotor starts on the
  first drive pulse and then coasts, so pulses do not follow the PWM level.
*/
`timescale 1ns/1ps
module efp_fan_model #(
  parameter int HALF_CYCLES = 20 // Tach half period in clocks
) (
  input wire logic clk_in, // Bench clock
  input wire logic reset_in, // Async reset, active high
  input wire logic pwm_in, // PWM drive from the controller
  output logic tach_out // Open-collector tach, pulled up
);
  int cnt;
  logic spinning;
  // ----------------------------------------------------------------
  // Rotor pulses
  // ----------------------------------------------------------------
  // Pull-up holds the line high while the rotor is reset
  always @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      cnt <= 0;
      spinning <= 1'b0;
      tach_out <= 1'b1;
    end else if (!spinning) begin
      spinning <= pwm_in;
    end else if (cnt == HALF_CYCLES - 1) begin
      cnt <= 0;
      tach_out <= ~tach_out;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : efp_fan_model
